//--- core/odps_consts.svh
/*
 Constants for the operation-data profile selector: value limits,
 factory values, field positions and ramp timing.
 Assumes inclusion by bare name from the core files.
*/
`ifndef ODPS_CONSTS_SVH
`define ODPS_CONSTS_SVH

// Entry count
`define ODPS_ENTRIES 8
// Speed limits in r/min
`define ODPS_SPEED_MIN 16'h0050
`define ODPS_SPEED_MAX 16'h0C4E
`define ODPS_SPEED_DEF 12'h050
`define ODPS_SPEED_POT_DEF 12'h000
// Ramp times in 0.1 s units
`define ODPS_RAMP_MIN 16'h0001
`define ODPS_RAMP_MAX 16'h0096
`define ODPS_RAMP_DEF 8'h05
// Torque limit in percent of rated torque
`define ODPS_TRQ_MIN 16'h0000
`define ODPS_TRQ_MAX 16'h00C8
`define ODPS_TRQ_DEF 8'hC8
// Entry word layout
`define ODPS_F_SPEED_LSB 0
`define ODPS_F_ACCEL_LSB 12
`define ODPS_F_DECEL_LSB 20
`define ODPS_F_TRQ_LSB 28
`define ODPS_ENTRY_W 36
// Ramp reference and update timing
`define ODPS_RAMP_REF_RPM 3000
`define ODPS_RAMP_UNIT_US 100000
`define ODPS_UPDATE_US 1000
`define ODPS_CLK_MHZ 40
`define ODPS_TICK_CYCLES (`ODPS_UPDATE_US * `ODPS_CLK_MHZ)
// Step numerator in r/min x 256 per update per ramp unit
`define ODPS_STEP_NUM (`ODPS_RAMP_REF_RPM * 256 * `ODPS_UPDATE_US / `ODPS_RAMP_UNIT_US)

`endif

//--- core/odps_pkg.sv
/*
 Types for the operation-data profile selector.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package odps_pkg;

	// Where a value comes from
	typedef enum logic [1:0] {
		ODPS_SRC_DIGITAL,
		ODPS_SRC_POT_ONE,
		ODPS_SRC_POT_TWO,
		ODPS_SRC_EXTERNAL
	} odps_src_t;

	// Which item a setting write targets
	typedef enum logic [2:0] {
		ODPS_FLD_SPEED,
		ODPS_FLD_ACCEL,
		ODPS_FLD_DECEL,
		ODPS_FLD_TORQUE,
		ODPS_FLD_SOURCES
	} odps_field_t;

	// Source set of one entry, packed as written
	typedef struct packed {
		odps_src_t decel;
		odps_src_t accel;
		odps_src_t torque;
		odps_src_t speed;
	} odps_srcset_t;

endpackage

//--- core/odps_entry_mem.sv
/*
 Small entry store: one masked write port, one registered read port.
 Assumes one clock, asynchronous active-low reset to RESET_WORD.
*/
`timescale 1ns/1ps
`default_nettype none

module odps_entry_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3,
	parameter int W = 36,
	parameter logic [W-1:0] RESET_WORD = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_mask,
	input wire logic [W-1:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
);

	logic [W-1:0] mem [DEPTH];      // Entry words
	logic [W-1:0] next_mem [DEPTH]; // Next entry words
	logic [W-1:0] next_rd;          // Next read word

	// Masked merge, so fields are written one at a time
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
		end
		if (wr_en) begin
			next_mem[wr_addr] = (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
		end
		next_rd = mem[rd_addr];
	end

	// Register store and read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= RESET_WORD;
			end
			rd_data <= RESET_WORD; // Read word matches the store from the first cycle
		end else begin
			mem <= next_mem;
			rd_data <= next_rd;
		end
	end

endmodule

`default_nettype wire

//--- core/odps_selector.sv
/*
 Operation-data profile selector: eight entries, source selection,
 conflict flags, torque cap gating and a linear speed ramp.
 Assumes pot and external samples come from same-clock logic, while
 select, run and torque-cap pins are asynchronous.
*/
// What this block does
// RULE1 - Keep eight entries with four values
// RULE2 - Acceleration time means standstill to 3000
// RULE3 - Deceleration time means 3000 to standstill
// RULE4 - Torque limit percent, zero to 200
// RULE5 - Source changes apply only when stopped
// RULE6 - Factory sources per entry as listed
// RULE7 - Allowed sources per value kind
// RULE8 - Same non-digital speed/torque source flags error
// RULE9 - Conflicting entry refuses run, raises flag
// RULE10 - Digital speed 80 to 3150, default 80
// RULE11 - Pot speed defaults to zero
// RULE12 - Digital ramp 0.1 to 15.0, default 0.5
// RULE13 - Pot ramp 0.1 to 15.0, rising
// RULE14 - Parameter picks analog or PWM external
// RULE15 - Cap torque only while enable active
// RULE16 - Unmapped enable counts as always active
// RULE17 - Multiple mapped terminals all must be on
// RULE18 - Three select inputs pick entry, MSB first
// RULE19 - Drive error and refused flag outputs
// RULE20 - Linear ramp step from 3000 and time
// RULE21 - Clamp out-of-range digital writes
`timescale 1ns/1ps
`default_nettype none
`include "odps_consts.svh"

module odps_selector #(
	parameter int TL_PINS = 2,
	parameter int TICK_CYCLES = `ODPS_TICK_CYCLES,
	parameter logic [7:0] TORQUE_PEAK_PCT = 8'hFF
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Setting writes
	input wire logic WR_EN,
	input wire logic [2:0] WR_ENTRY,
	input wire odps_pkg::odps_field_t WR_FIELD,
	input wire logic [15:0] WR_DATA,
	// Control pins
	input wire logic ENTRY_SELECT_BIT0,
	input wire logic ENTRY_SELECT_BIT1,
	input wire logic ENTRY_SELECT_BIT2,
	input wire logic RUN_REQUEST,
	input wire logic [TL_PINS-1:0] TORQUE_CAP_ENABLE_INPUT,
	// Configuration
	input wire logic [TL_PINS-1:0] TORQUE_CAP_MAP,
	input wire logic EXT_USE_PWM,
	// Setting device samples
	input wire logic [11:0] INTERNAL_POT_ONE,
	input wire logic [11:0] INTERNAL_POT_TWO,
	input wire logic [11:0] EXT_ANALOG_LEVEL,
	input wire logic [11:0] EXT_PWM_DUTY,
	// Drive stage
	input wire logic MOTOR_STOPPED,
	// Outputs to drive stage
	output logic [11:0] SPEED_REF,
	output logic [7:0] TORQUE_CAP_PCT,
	output logic TORQUE_CAP_ACTIVE,
	output logic RUN_GRANTED,
	// Information bits
	output logic SETTING_ERROR_FLAG,
	output logic RUN_REFUSED_FLAG,
	output logic [2:0] ACTIVE_ENTRY
);

	localparam int EW = `ODPS_ENTRY_W;
	localparam logic [19:0] STEP_NUM = 20'(`ODPS_STEP_NUM);
	localparam logic [EW-1:0] RESET_WORD = {`ODPS_TRQ_DEF, `ODPS_RAMP_DEF,
		`ODPS_RAMP_DEF, `ODPS_SPEED_DEF};

	// Clamp a written value into its range
	function automatic logic [15:0] clamp16(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// Map a 12-bit sample onto 0..full-1
	function automatic logic [11:0] scale12(input logic [11:0] raw,
		input logic [11:0] full);
		logic [23:0] p;
		p = {12'h000, raw} * {12'h000, full};
		return p[23:12];
	endfunction

	// Choose a value by its source
	function automatic logic [11:0] pick(input odps_pkg::odps_src_t s,
		input logic [11:0] dig, input logic [11:0] p1,
		input logic [11:0] p2, input logic [11:0] ext);
		unique case (s)
			odps_pkg::ODPS_SRC_DIGITAL: return dig;
			odps_pkg::ODPS_SRC_POT_ONE: return p1;
			odps_pkg::ODPS_SRC_POT_TWO: return p2;
			odps_pkg::ODPS_SRC_EXTERNAL: return ext;
		endcase
	endfunction

	// Speed and torque on one shared non-digital source
	function automatic logic clash(input odps_pkg::odps_srcset_t s);
		return (s.speed == s.torque) && (s.speed != odps_pkg::ODPS_SRC_DIGITAL);
	endfunction

	// Factory source set of an entry
	function automatic odps_pkg::odps_srcset_t factory_src(input int i);
		odps_pkg::odps_srcset_t s;
		s = '{default: odps_pkg::ODPS_SRC_DIGITAL};
		if (i < 2) begin
			s.accel = odps_pkg::ODPS_SRC_POT_TWO;
			s.decel = odps_pkg::ODPS_SRC_POT_TWO;
		end
		if (i == 0) begin
			s.speed = odps_pkg::ODPS_SRC_EXTERNAL;
		end else if (i == 1) begin
			s.speed = odps_pkg::ODPS_SRC_POT_ONE;
		end
		return s;
	endfunction

	// Input pin synchronisers
	logic [2:0] sel_m, sel_s;
	logic run_m, run_s;
	logic [TL_PINS-1:0] tl_m, tl_s;

	// Two flops on every asynchronous pin
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_m <= 3'h0;
			sel_s <= 3'h0;
			run_m <= 1'b0;
			run_s <= 1'b0;
			tl_m <= '0;
			tl_s <= '0;
		end else begin
			sel_m <= {ENTRY_SELECT_BIT2, ENTRY_SELECT_BIT1, ENTRY_SELECT_BIT0}; // RULE18
			sel_s <= sel_m;
			run_m <= RUN_REQUEST;
			run_s <= run_m;
			tl_m <= TORQUE_CAP_ENABLE_INPUT;
			tl_s <= tl_m;
		end
	end

	// Source selections: written set and applied set
	odps_pkg::odps_srcset_t [7:0] pend_src, next_pend_src;
	odps_pkg::odps_srcset_t [7:0] act_src, next_act_src;
	odps_pkg::odps_srcset_t wr_src; // Sanitised write

	// Pending sets follow writes; applied sets catch up at standstill
	always_comb begin
		wr_src = odps_pkg::odps_srcset_t'(WR_DATA[7:0]);
		if (wr_src.accel == odps_pkg::ODPS_SRC_EXTERNAL) begin
			wr_src.accel = odps_pkg::ODPS_SRC_DIGITAL; // RULE7
		end
		if (wr_src.decel == odps_pkg::ODPS_SRC_EXTERNAL) begin
			wr_src.decel = odps_pkg::ODPS_SRC_DIGITAL; // RULE7
		end
		next_pend_src = pend_src;
		if (WR_EN && WR_FIELD == odps_pkg::ODPS_FLD_SOURCES) begin
			next_pend_src[WR_ENTRY] = wr_src;
		end
		// A change mid-run would jerk the drive, so it waits
		next_act_src = MOTOR_STOPPED ? pend_src : act_src; // RULE5
	end

	// Register source sets, factory values at reset
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < `ODPS_ENTRIES; i++) begin
				pend_src[i] <= factory_src(i); // RULE6
				act_src[i] <= factory_src(i);
			end
		end else begin
			pend_src <= next_pend_src;
			act_src <= next_act_src;
		end
	end

	// Digital value writes into the entry store
	logic mem_we;
	logic [EW-1:0] wr_mask, wr_word, rd_word;
	logic [15:0] wr_clamped;

	// Build mask and clamped value per field
	always_comb begin
		mem_we = WR_EN && (WR_FIELD != odps_pkg::ODPS_FLD_SOURCES);
		wr_mask = '0;
		wr_word = '0;
		wr_clamped = 16'h0000;
		unique case (WR_FIELD)
			odps_pkg::ODPS_FLD_SPEED: begin
				wr_clamped = clamp16(WR_DATA, `ODPS_SPEED_MIN, `ODPS_SPEED_MAX); // RULE10 RULE21
				wr_mask[`ODPS_F_SPEED_LSB +: 12] = 12'hFFF;
				wr_word[`ODPS_F_SPEED_LSB +: 12] = wr_clamped[11:0];
			end
			odps_pkg::ODPS_FLD_ACCEL: begin
				wr_clamped = clamp16(WR_DATA, `ODPS_RAMP_MIN, `ODPS_RAMP_MAX); // RULE12 RULE21
				wr_mask[`ODPS_F_ACCEL_LSB +: 8] = 8'hFF;
				wr_word[`ODPS_F_ACCEL_LSB +: 8] = wr_clamped[7:0];
			end
			odps_pkg::ODPS_FLD_DECEL: begin
				wr_clamped = clamp16(WR_DATA, `ODPS_RAMP_MIN, `ODPS_RAMP_MAX); // RULE12 RULE21
				wr_mask[`ODPS_F_DECEL_LSB +: 8] = 8'hFF;
				wr_word[`ODPS_F_DECEL_LSB +: 8] = wr_clamped[7:0];
			end
			odps_pkg::ODPS_FLD_TORQUE: begin
				wr_clamped = clamp16(WR_DATA, `ODPS_TRQ_MIN, `ODPS_TRQ_MAX); // RULE4 RULE21
				wr_mask[`ODPS_F_TRQ_LSB +: 8] = 8'hFF;
				wr_word[`ODPS_F_TRQ_LSB +: 8] = wr_clamped[7:0];
			end
			odps_pkg::ODPS_FLD_SOURCES: begin
				wr_mask = '0;
			end
		endcase
	end

	// Eight stored entries, read data one cycle behind the select
	odps_entry_mem #(
		.DEPTH(`ODPS_ENTRIES),
		.AW(3),
		.W(EW),
		.RESET_WORD(RESET_WORD)
	) u_entries (
		.clk(MCLK),
		.rst_n(RST_N),
		.wr_en(mem_we),
		.wr_addr(WR_ENTRY),
		.wr_mask(wr_mask),
		.wr_data(wr_word),
		.rd_addr(sel_s),
		.rd_data(rd_word)
	); // RULE1

	// Effective values of the entry in use
	odps_pkg::odps_srcset_t cur_src;
	logic [11:0] ext_raw, spd_pot1, spd_pot2, spd_ext, cur_speed;
	logic [11:0] rmp_pot1, rmp_pot2, cur_accel, cur_decel, cur_trq;
	logic [7:0] ramp_t;
	logic [19:0] target_q, step;
	logic [19:0] ref_q, next_ref_q; // Speed reference with 8 fraction bits
	logic [7:0] conf_vec;
	logic cap_en, run_ok;

	// Resolve sources, conflicts and torque enable
	always_comb begin
		cur_src = act_src[ACTIVE_ENTRY];
		ext_raw = EXT_USE_PWM ? EXT_PWM_DUTY : EXT_ANALOG_LEVEL; // RULE14
		spd_pot1 = `ODPS_SPEED_POT_DEF + scale12(INTERNAL_POT_ONE, 12'(`ODPS_SPEED_MAX)); // RULE11
		spd_pot2 = `ODPS_SPEED_POT_DEF + scale12(INTERNAL_POT_TWO, 12'(`ODPS_SPEED_MAX));
		spd_ext = scale12(ext_raw, 12'(`ODPS_SPEED_MAX));
		// Pot at zero gives the shortest ramp, full gives the longest
		rmp_pot1 = scale12(INTERNAL_POT_ONE, 12'(`ODPS_RAMP_MAX)) + 12'(`ODPS_RAMP_MIN); // RULE13
		rmp_pot2 = scale12(INTERNAL_POT_TWO, 12'(`ODPS_RAMP_MAX)) + 12'(`ODPS_RAMP_MIN); // RULE13
		cur_speed = pick(cur_src.speed, rd_word[`ODPS_F_SPEED_LSB +: 12],
			spd_pot1, spd_pot2, spd_ext);
		cur_accel = pick(cur_src.accel, {4'h0, rd_word[`ODPS_F_ACCEL_LSB +: 8]},
			rmp_pot1, rmp_pot2, {4'h0, rd_word[`ODPS_F_ACCEL_LSB +: 8]});
		cur_decel = pick(cur_src.decel, {4'h0, rd_word[`ODPS_F_DECEL_LSB +: 8]},
			rmp_pot1, rmp_pot2, {4'h0, rd_word[`ODPS_F_DECEL_LSB +: 8]});
		cur_trq = pick(cur_src.torque, {4'h0, rd_word[`ODPS_F_TRQ_LSB +: 8]},
			scale12(INTERNAL_POT_ONE, 12'(`ODPS_TRQ_MAX)),
			scale12(INTERNAL_POT_TWO, 12'(`ODPS_TRQ_MAX)),
			scale12(ext_raw, 12'(`ODPS_TRQ_MAX))); // RULE4
		for (int i = 0; i < `ODPS_ENTRIES; i++) begin
			conf_vec[i] = clash(act_src[i]); // RULE8
		end
		run_ok = run_s && !conf_vec[ACTIVE_ENTRY]; // RULE9
		// Unmapped pins count as on; mapped ones must all be on
		cap_en = &(tl_s | ~TORQUE_CAP_MAP); // RULE16 RULE17
		target_q = run_ok ? {cur_speed, 8'h00} : 20'h00000;
		ramp_t = (ref_q < target_q) ? cur_accel[7:0] : cur_decel[7:0]; // RULE2 RULE3
		// Ramp time is never zero, both paths floor at the minimum
		step = STEP_NUM / {12'h000, ramp_t}; // RULE20
	end

	// Ramp state: update tick and speed reference with 8 fraction bits
	logic [31:0] tick_cnt, next_tick_cnt;
	logic tick;

	// Move the reference one step per update, never past the target
	always_comb begin
		tick = (tick_cnt == 32'(TICK_CYCLES - 1));
		next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
		next_ref_q = ref_q;
		if (tick) begin
			if (ref_q < target_q) begin
				next_ref_q = (target_q - ref_q > step) ? ref_q + step : target_q; // RULE2 RULE20
			end else if (ref_q > target_q) begin
				next_ref_q = (ref_q - target_q > step) ? ref_q - step : target_q; // RULE3 RULE20
			end
		end
	end

	// Register ramp state
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt <= 32'h00000000;
			ref_q <= 20'h00000;
		end else begin
			tick_cnt <= next_tick_cnt;
			ref_q <= next_ref_q;
		end
	end

	// Output values
	logic [7:0] next_trq_pct;
	logic next_cap_active, next_grant, next_err, next_refuse;

	// Torque cap, grant and information bits
	always_comb begin
		next_trq_pct = cap_en ? cur_trq[7:0] : TORQUE_PEAK_PCT; // RULE15
		next_cap_active = cap_en; // RULE15
		next_grant = run_ok; // RULE9
		next_err = |conf_vec; // RULE8 RULE19
		next_refuse = run_s && conf_vec[ACTIVE_ENTRY]; // RULE9 RULE19
	end

	// Register outputs; entry number tracks the read data
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			SPEED_REF <= 12'h000;
			TORQUE_CAP_PCT <= 8'h00;
			TORQUE_CAP_ACTIVE <= 1'b0;
			RUN_GRANTED <= 1'b0;
			SETTING_ERROR_FLAG <= 1'b0;
			RUN_REFUSED_FLAG <= 1'b0;
			ACTIVE_ENTRY <= 3'h0;
		end else begin
			SPEED_REF <= next_ref_q[19:8];
			TORQUE_CAP_PCT <= next_trq_pct;
			TORQUE_CAP_ACTIVE <= next_cap_active;
			RUN_GRANTED <= next_grant;
			SETTING_ERROR_FLAG <= next_err;
			RUN_REFUSED_FLAG <= next_refuse;
			ACTIVE_ENTRY <= sel_s; // RULE18
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence run_blocked;
		run_s && conf_vec[ACTIVE_ENTRY];
	endsequence

	sequence cap_off;
		!cap_en;
	endsequence

	refuse_on_conflict_a: assert property (run_blocked |=> RUN_REFUSED_FLAG && !RUN_GRANTED) // RULE9
		else $error("run not refused on a conflicting entry");
	error_flag_a: assert property ((|conf_vec) |=> SETTING_ERROR_FLAG) // RULE8
		else $error("setting error flag missing");
	peak_torque_a: assert property (cap_off |=> TORQUE_CAP_PCT == TORQUE_PEAK_PCT
		&& !TORQUE_CAP_ACTIVE) // RULE15
		else $error("torque capped while enable inactive");
	cap_unmapped_a: assert property ((TORQUE_CAP_MAP == '0) |=> TORQUE_CAP_ACTIVE) // RULE16
		else $error("unmapped enable not treated as on");
	cap_partial_a: assert property (((TORQUE_CAP_MAP & ~tl_s) != '0) |=> !TORQUE_CAP_ACTIVE) // RULE17
		else $error("cap active with a mapped terminal off");
	torque_range_a: assert property (TORQUE_CAP_ACTIVE |-> TORQUE_CAP_PCT <= 8'hC8) // RULE4
		else $error("torque cap above range");
	src_hold_a: assert property (!MOTOR_STOPPED |=> act_src == $past(act_src)) // RULE5
		else $error("sources changed while running");
	src_apply_a: assert property (MOTOR_STOPPED |=> act_src == $past(pend_src)) // RULE5
		else $error("pending sources not applied at standstill");
	speed_max_a: assert property (SPEED_REF <= 12'hC4E) // RULE10
		else $error("speed reference above range");
	ramp_step_a: assert property (tick |=> ((ref_q >= $past(ref_q)) ? ref_q - $past(ref_q)
		: $past(ref_q) - ref_q) <= $past(step)) // RULE20
		else $error("ramp step too large");
	ramp_hold_a: assert property (!tick |=> ref_q == $past(ref_q)) // RULE20
		else $error("reference moved between updates");
	ramp_time_a: assert property (ramp_t >= 8'h01 && ramp_t <= 8'h96) // RULE12
		else $error("ramp time out of range");

endmodule

`default_nettype wire

//--- sim/odps_setting_devices.sv
/*
 Far-side model: select switches and setting devices of the selector.
 Assumes the bench gives the wanted entry, the pot-two and external levels; pot one sits at POT_ONE_LEVEL.
*/
`timescale 1ns/1ps
`default_nettype none

module odps_setting_devices #(
	parameter logic [11:0] POT_ONE_LEVEL = 12'h800
) (
	// Bench commands
	input wire logic [2:0] entry,
	input wire logic [11:0] pot_two_level,
	input wire logic [11:0] analog_level,
	input wire logic [11:0] pwm_level,
	// Pins toward the selector
	output logic entry_select_bit0,
	output logic entry_select_bit1,
	output logic entry_select_bit2,
	output logic [11:0] internal_pot_one,
	output logic [11:0] internal_pot_two,
	output logic [11:0] ext_analog_level,
	output logic [11:0] ext_pwm_duty
);
	// Binary select, bit2 most significant
	always_comb begin
		entry_select_bit2 = entry[2];
		entry_select_bit1 = entry[1];
		entry_select_bit0 = entry[0];
	end
	// Knobs and external sources just hold their level
	assign internal_pot_one = POT_ONE_LEVEL;
	assign internal_pot_two = pot_two_level;
	assign ext_analog_level = analog_level;
	assign ext_pwm_duty = pwm_level;
endmodule

`default_nettype wire

//--- sim/tb_top.sv
/*
 Self-checking bench for the operation-data profile selector.
 Assumes the selector and the setting-device model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// Short tick so ramps finish quickly; step size is unchanged
	localparam int TICK = 8;
	logic mclk, rst_n, wr_en, run, use_pwm, stopped;
	logic [2:0] wr_entry, entry, act;
	odps_pkg::odps_field_t wr_field;
	logic [15:0] wr_data;
	logic [1:0] cap_en, cap_map;
	logic [11:0] pot2, ana, pwm, p1, p2, ea, ep, speed_ref;
	logic s0, s1, s2, cap_on, granted, set_err, refused;
	logic [7:0] cap_pct;
	logic [11:0] a, b;
	int bad_count, checked;

	odps_setting_devices u_dev (.entry(entry), .pot_two_level(pot2), .analog_level(ana),
		.pwm_level(pwm), .entry_select_bit0(s0), .entry_select_bit1(s1),
		.entry_select_bit2(s2), .internal_pot_one(p1), .internal_pot_two(p2),
		.ext_analog_level(ea), .ext_pwm_duty(ep));

	odps_selector #(.TL_PINS(2), .TICK_CYCLES(TICK)) u_dut (.MCLK(mclk), .RST_N(rst_n),
		.WR_EN(wr_en), .WR_ENTRY(wr_entry), .WR_FIELD(wr_field), .WR_DATA(wr_data),
		.ENTRY_SELECT_BIT0(s0), .ENTRY_SELECT_BIT1(s1), .ENTRY_SELECT_BIT2(s2),
		.RUN_REQUEST(run), .TORQUE_CAP_ENABLE_INPUT(cap_en), .TORQUE_CAP_MAP(cap_map),
		.EXT_USE_PWM(use_pwm), .INTERNAL_POT_ONE(p1), .INTERNAL_POT_TWO(p2),
		.EXT_ANALOG_LEVEL(ea), .EXT_PWM_DUTY(ep), .MOTOR_STOPPED(stopped),
		.SPEED_REF(speed_ref), .TORQUE_CAP_PCT(cap_pct), .TORQUE_CAP_ACTIVE(cap_on),
		.RUN_GRANTED(granted), .SETTING_ERROR_FLAG(set_err), .RUN_REFUSED_FLAG(refused),
		.ACTIVE_ENTRY(act));

	// Free-running 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe, launched off the falling edge
	task automatic wr(input logic [2:0] e, input odps_pkg::odps_field_t f, input logic [15:0] d);
		@(negedge mclk);
		wr_en = 1'b1;
		wr_entry = e;
		wr_field = f;
		wr_data = d;
		@(negedge mclk);
		wr_en = 1'b0;
	endtask

	// Wait n falling edges
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Verdict, shared by the main flow and the watchdog
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Factory state, select walk and default speed
	task automatic s_reset;
		chk(set_err, 1'b0, "set_err");
		chk(cap_on, 1'b1, "cap_on");
		chk(cap_pct, 8'hC8, "cap_pct");
		for (int i = 0; i < 8; i++) begin
			entry = i[2:0];
			idle(8);
			chk(act, i[2:0], "active_entry");
		end
		entry = 3'h2;
		run = 1'b1;
		idle(200);
		chk(speed_ref, 12'h050, "speed_default");
		run = 1'b0;
		idle(200);
		chk(speed_ref, 12'h000, "speed_stop");
	endtask

	// Clamped writes and ramp slopes against the 3000 reference
	task automatic s_ramp;
		wr(3'h2, odps_pkg::ODPS_FLD_SPEED, 16'hFFFF);
		wr(3'h2, odps_pkg::ODPS_FLD_ACCEL, 16'h0000);
		wr(3'h2, odps_pkg::ODPS_FLD_DECEL, 16'h0002);
		run = 1'b1;
		idle(40);
		a = speed_ref;
		idle(10 * TICK);
		b = speed_ref;
		chk(b - a, 12'h12C, "accel_slope");
		idle(1000);
		chk(speed_ref, 12'hC4E, "speed_clamp");
		chk(granted, 1'b1, "granted");
		run = 1'b0;
		idle(40);
		a = speed_ref;
		idle(10 * TICK);
		b = speed_ref;
		chk(a - b, 12'h096, "decel_slope");
		idle(1800);
		chk(speed_ref, 12'h000, "decel_end");
	endtask

	// Source conflict, refusal and change held while running
	task automatic s_conflict;
		wr(3'h3, odps_pkg::ODPS_FLD_SOURCES, 16'h0005);
		idle(6);
		chk(set_err, 1'b1, "set_err");
		entry = 3'h3;
		run = 1'b1;
		idle(8);
		chk(refused, 1'b1, "refused");
		chk(granted, 1'b0, "granted");
		run = 1'b0;
		stopped = 1'b0;
		wr(3'h3, odps_pkg::ODPS_FLD_SOURCES, 16'h0000);
		idle(10);
		chk(set_err, 1'b1, "held_while_running");
		stopped = 1'b1;
		idle(6);
		chk(set_err, 1'b0, "applied_when_stopped");
	endtask

	// Torque value, clamp and enable mapping
	task automatic s_torque;
		entry = 3'h4;
		wr(3'h4, odps_pkg::ODPS_FLD_TORQUE, 16'h0032);
		idle(8);
		chk(cap_pct, 8'h32, "cap_pct");
		wr(3'h4, odps_pkg::ODPS_FLD_TORQUE, 16'h00FA);
		cap_map = 2'b11;
		cap_en = 2'b01;
		idle(8);
		chk(cap_on, 1'b0, "cap_partial");
		chk(cap_pct, 8'hFF, "cap_peak");
		cap_en = 2'b11;
		idle(8);
		chk(cap_pct, 8'hC8, "cap_clamp");
	endtask

	// Entry 0 external speed: analog or duty input chosen by config
	task automatic s_ext;
		entry = 3'h0;
		ana = 12'h800;
		run = 1'b1;
		idle(500);
		chk(speed_ref, 12'h627, "ext_analog");
		use_pwm = 1'b1;
		idle(500);
		chk(speed_ref, 12'hC4D, "ext_pwm");
		run = 1'b0;
	endtask

	// Main sequence
	initial begin
		bad_count = 0;
		checked = 0;
		rst_n = 1'b0;
		wr_en = 1'b0;
		wr_entry = 3'h0;
		wr_field = odps_pkg::ODPS_FLD_SPEED;
		wr_data = 16'h0000;
		run = 1'b0;
		use_pwm = 1'b0;
		stopped = 1'b1;
		entry = 3'h2;
		cap_en = 2'b00;
		cap_map = 2'b00;
		pot2 = 12'h000;
		ana = 12'h000;
		pwm = 12'hFFF;
		idle(5);
		rst_n = 1'b1;
		idle(4);
		s_reset();
		s_ramp();
		s_conflict();
		s_torque();
		s_ext();
		end_of_test();
	end

	// Watchdog well past the expected run of about 4600 cycles
	initial begin
		repeat (30000) @(posedge mclk);
		bad_count++;
		end_of_test();
	end
endmodule

`default_nettype wire
